// ### src/cmf_pkg.sv
package cmf_pkg;
    // ==========================================================
    // Frame initialisation byte fields
    localparam int unsigned FRM_BIT      = 7;
    localparam int unsigned REQ_LSB      = 4;
    localparam int unsigned SIZE_LSB     = 0;
    localparam logic [2:0]  REQ_SINGLE_R = 3'h0;
    localparam logic [2:0]  REQ_SINGLE_N = 3'h1;
    localparam logic [2:0]  REQ_GROUP_R  = 3'h2;
    localparam logic [2:0]  REQ_GROUP_N  = 3'h3;
    localparam logic [2:0]  REQ_BCAST_R  = 3'h6;
    localparam logic [2:0]  REQ_BCAST_N  = 3'h7;
    localparam logic [2:0]  LEN_CMD_ONLY = 3'h1;
    localparam logic [2:0]  LEN_CMD_CHAN = 3'h5;
    localparam logic [2:0]  LEN_CMD_AVG  = 3'h6;
    // ==========================================================
    // Device register offsets and reset values
    localparam logic [7:0]  REG_SAMPLE_COMMAND   = 8'h02;
    localparam logic [7:0]  REG_CHANNEL_SELECT   = 8'h03;
    localparam logic [7:0]  REG_SAMPLE_AVERAGING = 8'h07;
    localparam logic [7:0]  REG_SAMPLING_PERIOD  = 8'h43;
    localparam logic [31:0] RST_CHANNEL_SELECT   = 32'h0000_0000;
    localparam logic [7:0]  RST_SAMPLE_AVERAGING = 8'h00;
    localparam logic [15:0] RST_SAMPLING_PERIOD  = 16'h0000;
    // ==========================================================
    // Host APB register offsets
    localparam logic [7:0]  APB_CTRL   = 8'h00;
    localparam logic [7:0]  APB_STATUS = 8'h04;
    localparam logic [7:0]  APB_TXDATA = 8'h08;
    localparam logic [7:0]  APB_RXDATA = 8'h0c;
    localparam logic [7:0]  APB_COUNT  = 8'h10;
    // ==========================================================
    // CRC-16-IBM, reflected, zero start
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    // Sampling delay unit per period count
    localparam int unsigned PERIOD_UNIT_CYC = 4;

    // One byte, least significant bit first through the CRC
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000, DEV_HDR = 3'b001, DEV_BODY = 3'b011,
        DEV_WAIT = 3'b010, DEV_SEND = 3'b110, DEV_CRC = 3'b111
    } cmf_dev_state_t;
endpackage

// ### src/cmf_link_if.sv
`timescale 1ns/1ns
interface cmf_link_if;
    logic [7:0] cmd_data;
    logic       cmd_valid;
    logic       cmd_ready;
    logic       cmd_last;
    logic [7:0] rsp_data;
    logic       rsp_valid;
    logic       rsp_ready;
    logic       rsp_last;
    modport dev (input cmd_data, cmd_valid, cmd_last, rsp_ready,
                 output cmd_ready, rsp_data, rsp_valid, rsp_last);
    modport host (output cmd_data, cmd_valid, cmd_last, rsp_ready,
                  input cmd_ready, rsp_data, rsp_valid, rsp_last);
endinterface

// ### src/cmf_fifo.sv
`timescale 1ns/1ns
module cmf_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // Fill side
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic             i_wvalid,
    output logic                  o_wready,
    // Drain side
    output logic      [WIDTH-1:0] o_rdata,
    output logic                  o_rvalid,
    input  wire logic             i_rready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign o_wready = (cnt_r != (AW+1)'(DEPTH));
    assign o_rvalid = (cnt_r != '0);
    assign o_rdata  = mem[rp_r];
    assign push     = i_ce && i_wvalid && o_wready;
    assign pop      = i_ce && i_rready && o_rvalid;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_r] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### src/cmf_device.sv
// Our own choice: the APB register port.
`timescale 1ns/1ns
// How it works
// - CRC low byte goes first, high second
// - Request type decides response or silence
// - With-response types answer, without-response stay silent
// - One response per addressed device
// - Response carries init, data, CRC bytes
// - At most one response per command
// - Sample response length follows channel select
// - Sample response delayed by sampling period
// - Omitted select/averaging bytes keep old values
// - Included select/averaging bytes overwrite registers
// - Other register: data byte is count minus one
// - Sender sets length field to data count
// - Length 1 command, 5 adds select, 6 averaging
// - Sample response: two bytes per channel
// - CRC-16-IBM from zero, LSB-first order
// - Bytes sent least significant bit first
// - Whole frame through CRC leaves zero
module cmf_device #(
    parameter logic [7:0] DEV_ADDR = 8'h00
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    // Link
    cmf_link_if.dev   link,
    // Sample source and state
    input  wire logic [15:0] i_sample,
    output logic             o_busy,
    output logic             o_crc_err
);
    cmf_pkg::cmf_dev_state_t st_r;
    logic [7:0]  buf_r [16];
    logic [3:0]  nbyte_r;
    logic [15:0] crc_r;
    logic [31:0] chsel_r;
    logic [7:0]  avg_r;
    logic [15:0] period_r;
    logic [7:0]  cmd_r;
    logic [5:0]  chan_r;
    logic [7:0]  left_r;
    logic [7:0]  addr_r;
    logic        lo_r;
    logic [19:0] wait_r;
    logic [7:0]  out_r;
    logic        outv_r;
    logic        outl_r;
    logic        cmd_rdy_r;
    logic [15:0] crc_out;

    // ==========================================================
    // Helpers
    function automatic logic [5:0] popcnt(input logic [31:0] v);
        logic [5:0] n;
        n = '0;
        for (int i = 0; i < 32; i++) begin
            n = n + 6'(v[i]);
        end
        return n;
    endfunction

    function automatic logic [7:0] reg_rd(input logic [7:0] a, input logic [31:0] cs,
                                          input logic [7:0] av, input logic [15:0] pr,
                                          input logic [7:0] cm);
        logic [7:0] r;
        r = 8'h00;
        if (a == cmf_pkg::REG_SAMPLE_COMMAND) begin
            r = cm;
        end else if (a == cmf_pkg::REG_CHANNEL_SELECT) begin
            r = cs[31:24];
        end else if (a == cmf_pkg::REG_CHANNEL_SELECT + 8'h01) begin
            r = cs[23:16];
        end else if (a == cmf_pkg::REG_CHANNEL_SELECT + 8'h02) begin
            r = cs[15:8];
        end else if (a == cmf_pkg::REG_CHANNEL_SELECT + 8'h03) begin
            r = cs[7:0];
        end else if (a == cmf_pkg::REG_SAMPLE_AVERAGING) begin
            r = av;
        end else if (a == cmf_pkg::REG_SAMPLING_PERIOD) begin
            r = pr[15:8];
        end else if (a == cmf_pkg::REG_SAMPLING_PERIOD + 8'h01) begin
            r = pr[7:0];
        end
        return r;
    endfunction

    logic [2:0] req;
    logic [2:0] dsz;
    logic       resp_kind;
    logic       mine;
    logic       take;
    logic       give;
    assign req  = buf_r[0][cmf_pkg::REQ_LSB +: 3];
    assign dsz  = buf_r[0][cmf_pkg::SIZE_LSB +: 3];
    // Only the three with-response types answer; all others stay silent
    assign resp_kind = (req == cmf_pkg::REQ_SINGLE_R) || (req == cmf_pkg::REQ_GROUP_R)
                     || (req == cmf_pkg::REQ_BCAST_R);
    // Group addressing is out of scope: group and broadcast both match
    assign mine = (req != cmf_pkg::REQ_SINGLE_R && req != cmf_pkg::REQ_SINGLE_N)
                || buf_r[1] == DEV_ADDR;
    assign take = i_ce && link.cmd_valid && cmd_rdy_r;
    assign give = i_ce && outv_r && link.rsp_ready;
    // Residue once the byte now on the link has gone out
    assign crc_out = cmf_pkg::crc_byte(crc_r, out_r);

    assign link.cmd_ready = cmd_rdy_r;
    assign link.rsp_data  = out_r;
    assign link.rsp_valid = outv_r;
    assign link.rsp_last  = outl_r;

    // ==========================================================
    // Receive, decode, respond
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r      <= cmf_pkg::DEV_IDLE;
            nbyte_r   <= '0;
            crc_r     <= cmf_pkg::CRC_INIT;
            chsel_r   <= cmf_pkg::RST_CHANNEL_SELECT;
            avg_r     <= cmf_pkg::RST_SAMPLE_AVERAGING;
            period_r  <= cmf_pkg::RST_SAMPLING_PERIOD;
            cmd_r     <= 8'h00;
            chan_r    <= '0;
            left_r    <= '0;
            addr_r    <= '0;
            lo_r      <= 1'b0;
            wait_r    <= '0;
            out_r     <= 8'h00;
            outv_r    <= 1'b0;
            outl_r    <= 1'b0;
            cmd_rdy_r <= 1'b0;
            o_busy    <= 1'b0;
            o_crc_err <= 1'b0;
        end else if (i_ce) begin
            case (st_r)
                cmf_pkg::DEV_IDLE: begin
                    cmd_rdy_r <= 1'b1;
                    nbyte_r   <= '0;
                    crc_r     <= cmf_pkg::CRC_INIT;
                    o_busy    <= 1'b0;
                    if (take) begin
                        buf_r[0] <= link.cmd_data;
                        nbyte_r  <= 4'd1;
                        crc_r    <= cmf_pkg::crc_byte(cmf_pkg::CRC_INIT,
                                                      link.cmd_data);
                        st_r     <= cmf_pkg::DEV_HDR;
                    end
                end
                cmf_pkg::DEV_HDR: begin
                    if (take) begin
                        buf_r[nbyte_r] <= link.cmd_data;
                        if (nbyte_r != 4'hf) begin
                            nbyte_r <= nbyte_r + 4'd1;
                        end
                        crc_r <= cmf_pkg::crc_byte(crc_r, link.cmd_data);
                        if (link.cmd_last) begin
                            cmd_rdy_r <= 1'b0;
                            o_busy    <= 1'b1;
                            st_r      <= cmf_pkg::DEV_BODY;
                        end
                    end
                end
                cmf_pkg::DEV_BODY: begin
                    // Residue of a whole good frame is zero
                    if (crc_r != 16'h0000) begin
                        o_crc_err <= 1'b1;
                        st_r      <= cmf_pkg::DEV_IDLE;
                    end else if (!resp_kind || !mine) begin
                        o_crc_err <= 1'b0;
                        st_r      <= cmf_pkg::DEV_IDLE;
                    end else if (buf_r[2] == cmf_pkg::REG_SAMPLE_COMMAND) begin
                        o_crc_err <= 1'b0;
                        cmd_r     <= buf_r[3];
                        if (dsz == cmf_pkg::LEN_CMD_CHAN || dsz == cmf_pkg::LEN_CMD_AVG) begin
                            chsel_r <= {buf_r[4], buf_r[5], buf_r[6], buf_r[7]};
                            chan_r  <= popcnt({buf_r[4], buf_r[5], buf_r[6], buf_r[7]});
                        end else begin
                            chan_r  <= popcnt(chsel_r);
                        end
                        if (dsz == cmf_pkg::LEN_CMD_AVG) begin
                            avg_r <= buf_r[8];
                        end
                        lo_r   <= 1'b0;
                        wait_r <= 20'(period_r) * 20'(cmf_pkg::PERIOD_UNIT_CYC);
                        addr_r <= 8'h00;
                        st_r   <= cmf_pkg::DEV_WAIT;
                    end else begin
                        o_crc_err <= 1'b0;
                        if (buf_r[2] == cmf_pkg::REG_SAMPLING_PERIOD && dsz == 3'd2) begin
                            period_r <= {buf_r[3], buf_r[4]};
                        end
                        addr_r <= buf_r[2];
                        left_r <= buf_r[3];
                        chan_r <= '0;
                        lo_r   <= 1'b0;
                        wait_r <= '0;
                        st_r   <= cmf_pkg::DEV_WAIT;
                    end
                end
                cmf_pkg::DEV_WAIT: begin
                    if (wait_r != '0) begin
                        wait_r <= wait_r - 20'd1;
                    end else if (!outv_r) begin
                        // Init byte: response flag clear, size field holds byte count minus one
                        out_r  <= (chan_r != '0) ? 8'(({2'b00, chan_r} << 1) - 8'd1)
                                                 : left_r;
                        outv_r <= 1'b1;
                        outl_r <= 1'b0;
                        crc_r  <= cmf_pkg::CRC_INIT;
                        if (chan_r != '0) begin
                            left_r <= 8'(({2'b00, chan_r} << 1) - 8'd1);
                        end
                        st_r   <= cmf_pkg::DEV_SEND;
                    end
                end
                cmf_pkg::DEV_SEND: begin
                    if (give) begin
                        crc_r <= crc_out;
                        if (outl_r) begin
                            outl_r <= 1'b0;
                            outv_r <= 1'b0;
                            st_r   <= cmf_pkg::DEV_IDLE;
                        end else if (lo_r && left_r == 8'hff) begin
                            out_r <= crc_out[7:0];
                            st_r  <= cmf_pkg::DEV_CRC;
                        end else begin
                            // Odd count left: high byte of a channel's pair is next
                            out_r  <= (chan_r != '0) ? (left_r[0] ? i_sample[15:8] : i_sample[7:0])
                                    : reg_rd(addr_r, chsel_r, avg_r, period_r, cmd_r);
                            addr_r <= addr_r + 8'd1;
                            left_r <= left_r - 8'd1;
                            lo_r   <= 1'b1;
                        end
                    end
                end
                cmf_pkg::DEV_CRC: begin
                    if (give) begin
                        out_r  <= crc_r[15:8];
                        outl_r <= 1'b1;
                        st_r   <= cmf_pkg::DEV_SEND;
                    end
                end
                default: st_r <= cmf_pkg::DEV_IDLE;
            endcase
        end
    end
endmodule

// ### src/cmf_host.sv
`timescale 1ns/1ns
module cmf_host #(
    parameter int unsigned FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Link
    cmf_link_if.host         link
);
    logic [8:0]  tx_wdata;
    logic        tx_wvalid;
    logic        tx_wready;
    logic [8:0]  tx_rdata;
    logic        tx_rvalid;
    logic [15:0] crc_r;
    logic [1:0]  tail_r;
    logic [7:0]  rx_r;
    logic        rx_full_r;
    logic        rx_last_r;
    logic        rx_ok_r;
    logic [15:0] rx_crc_r;
    logic [7:0]  rx_cnt_r;
    logic        acc;

    assign acc       = i_ce && i_psel && i_penable && !o_pready;
    assign tx_wvalid = acc && i_pwrite && (i_paddr == cmf_pkg::APB_TXDATA);
    assign tx_wdata  = {i_pwdata[8], i_pwdata[7:0]};

    cmf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_wdata  (tx_wdata),
        .i_wvalid (tx_wvalid),
        .o_wready (tx_wready),
        .o_rdata  (tx_rdata),
        .o_rvalid (tx_rvalid),
        .i_rready (tail_r == 2'd0 && link.cmd_ready)
    );

    // ==========================================================
    // Command sender: appends the two CRC bytes after the last queued byte
    assign link.cmd_valid = tail_r != 2'd0 || tx_rvalid;
    assign link.cmd_data  = (tail_r == 2'd2) ? crc_r[7:0]
                          : (tail_r == 2'd1) ? crc_r[15:8] : tx_rdata[7:0];
    assign link.cmd_last  = (tail_r == 2'd1);
    assign link.rsp_ready = !rx_full_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_r  <= cmf_pkg::CRC_INIT;
            tail_r <= 2'd0;
        end else if (i_ce && link.cmd_ready) begin
            if (tail_r != 2'd0) begin
                tail_r <= tail_r - 2'd1;
                if (tail_r == 2'd1) begin
                    crc_r <= cmf_pkg::CRC_INIT;
                end
            end else if (tx_rvalid) begin
                crc_r <= cmf_pkg::crc_byte(crc_r, tx_rdata[7:0]);
                if (tx_rdata[8]) begin
                    tail_r <= 2'd2;
                end
            end
        end
    end

    // ==========================================================
    // Response receiver with running CRC check
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_r      <= 8'h00;
            rx_full_r <= 1'b0;
            rx_last_r <= 1'b0;
            rx_ok_r   <= 1'b0;
            rx_crc_r  <= cmf_pkg::CRC_INIT;
            rx_cnt_r  <= 8'h00;
        end else if (i_ce) begin
            if (link.rsp_valid && !rx_full_r) begin
                rx_r      <= link.rsp_data;
                rx_full_r <= 1'b1;
                rx_last_r <= link.rsp_last;
                rx_cnt_r  <= rx_cnt_r + 8'd1;
                if (link.rsp_last) begin
                    rx_ok_r  <= (cmf_pkg::crc_byte(rx_crc_r, link.rsp_data) == 16'h0000);
                    rx_crc_r <= cmf_pkg::CRC_INIT;
                end else begin
                    rx_crc_r <= cmf_pkg::crc_byte(rx_crc_r, link.rsp_data);
                end
            end else if (acc && !i_pwrite && i_paddr == cmf_pkg::APB_RXDATA) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // APB answer: one wait state (more while a TXDATA write finds the queue full), pready for a single cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready  <= acc && !(tx_wvalid && !tx_wready);
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            if (acc && !i_pwrite) begin
                if (i_paddr == cmf_pkg::APB_STATUS) begin
                    o_prdata <= {27'h0, rx_ok_r, rx_last_r, rx_full_r,
                                 tail_r != 2'd0 || tx_rvalid, tx_wready};
                end else if (i_paddr == cmf_pkg::APB_RXDATA) begin
                    o_prdata <= {23'h0, rx_last_r, rx_r};
                end else if (i_paddr == cmf_pkg::APB_COUNT) begin
                    o_prdata <= {24'h0, rx_cnt_r};
                end else if (i_paddr != cmf_pkg::APB_CTRL && i_paddr != cmf_pkg::APB_TXDATA) begin
                    o_pslverr <= 1'b1;
                end
            end else if (acc && i_pwrite && i_paddr != cmf_pkg::APB_TXDATA
                         && i_paddr != cmf_pkg::APB_CTRL) begin
                o_pslverr <= 1'b1;
            end
        end
    end

endmodule

// ### bench/cmf_link_sva.sv
`timescale 1ns/1ns
module cmf_link_sva (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       cmd_last,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_valid,
    input wire logic       rsp_ready,
    input wire logic       rsp_last
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic        ch, rh, quiet_r, done_r;
    logic [7:0]  cn_r, rn_r, ci_r, ri_r;
    logic [15:0] cc_r, rc_r, cc_nxt, rc_nxt;
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) x = x[0] ? ((x >> 1) ^ 16'ha001) : (x >> 1);
        return x;
    endfunction
    assign ch = cmd_valid && cmd_ready;
    assign rh = rsp_valid && rsp_ready;
    assign cc_nxt = crc8(cc_r, cmd_data);
    assign rc_nxt = crc8(rc_r, rsp_data);
    // ======
    // Frame trackers: byte count, running residue, first byte
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) {cn_r, cc_r, ci_r} <= 32'h0;
        else if (ch) {cn_r, cc_r, ci_r} <= cmd_last ? 32'h0 : {cn_r + 8'h01, cc_nxt,
            (cn_r == 8'h00) ? cmd_data : ci_r};
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) {rn_r, rc_r, ri_r} <= 32'h0;
        else if (rh) {rn_r, rc_r, ri_r} <= rsp_last ? 32'h0 : {rn_r + 8'h01, rc_nxt,
            (rn_r == 8'h00) ? rsp_data : ri_r};
    end
    // Quiet after a no-answer request; done after a full answer until next command
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) {quiet_r, done_r} <= 2'b00;
        else if (ch) {quiet_r, done_r} <= {cmd_last && ci_r[cmf_pkg::REQ_LSB], 1'b0};
        else if (rh && rsp_last) done_r <= 1'b1;
    end
    // ======
    AST_CMD_CRC: assert property (ch && cmd_last |-> cc_nxt == 16'h0000)
        else $error("command frame residue not zero");
    AST_CMD_LEN: assert property (ch && cmd_last |-> cn_r == {5'h00, ci_r[2:0]} + 8'h04)
        else $error("command frame length differs from length field");
    AST_RSP_CRC: assert property (rh && rsp_last |-> rc_nxt == 16'h0000)
        else $error("response frame residue not zero");
    AST_RSP_LEN: assert property (rh && rsp_last |-> rn_r == ri_r + 8'h03)
        else $error("response length differs from its init byte");
    AST_RSP_INIT: assert property (rsp_valid && rn_r == 8'h00 |-> !rsp_data[7])
        else $error("response init byte has frame bit set");
    AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid
        && $stable(rsp_data) && $stable(rsp_last))
        else $error("response byte changed while stalled");
    AST_QUIET: assert property (quiet_r |-> !rsp_valid)
        else $error("response to a no-answer request");
    AST_ONCE: assert property (done_r |-> !rsp_valid)
        else $error("second response to one command");
    COV_RSP: cover property (rh && rsp_last);
    COV_STALL: cover property (rsp_valid && !rsp_ready);
    COV_QUIET: cover property (ch && cmd_last && ci_r[cmf_pkg::REQ_LSB]);
endmodule

// ### bench/cmf_link_tb.sv
`timescale 1ns/1ns
module cmf_link_tb;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] smp = 16'h0;
    logic [31:0] prdata, rd, cs;
    logic        pready, pslverr, err, busy;
    logic [7:0]  av, f[$], d[$], seen[$];
    int          bad_count = 0;
    int          checks_done = 0;
    int          seed = 59637;
    always #20 i_clk = ~i_clk;
    cmf_link_if u_link();
    cmf_host u_cmf_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(u_link));
    cmf_device #(.DEV_ADDR(8'h03)) u_cmf_device (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .link(u_link), .i_sample(smp), .o_busy(busy), .o_crc_err());
    cmf_link_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .cmd_data(u_link.cmd_data),
        .cmd_valid(u_link.cmd_valid), .cmd_ready(u_link.cmd_ready), .cmd_last(u_link.cmd_last),
        .rsp_data(u_link.rsp_data), .rsp_valid(u_link.rsp_valid),
        .rsp_ready(u_link.rsp_ready), .rsp_last(u_link.rsp_last));
    always @(posedge i_clk) begin
        if (u_link.cmd_valid && u_link.cmd_ready) seen.push_back(u_link.cmd_data);
    end
    // ======
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge i_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 500);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) apb(1'b1, cmf_pkg::APB_TXDATA, {23'h0, i == q.size() - 1, q[i]});
    endtask
    // Wait until the frame is out and the device idle, then nothing may have come back
    task automatic quiet();
        int n;
        n = 0;
        do begin apb(1'b0, cmf_pkg::APB_STATUS, 32'h0); n++; end while (rd[1] !== 1'b0 && n < 99);
        while (busy === 1'b1 && n < 999) begin @(negedge i_clk); n++; end
        apb(1'b0, cmf_pkg::APB_STATUS, 32'h0);
        check(rd[2], 1'b0);
    endtask
    // Frames the expected answer around the data bytes and reads it back
    task automatic expect_rsp(input logic [7:0] q[$]);
        logic [15:0] c;
        int          n;
        q.push_front(8'(q.size() - 1));
        c = 16'h0000;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        q = {q, c[7:0], c[15:8]};
        foreach (q[i]) begin
            n = 0;
            do begin apb(1'b0, cmf_pkg::APB_STATUS, 32'h0); n++; end
            while (rd[2] !== 1'b1 && n < 999);
            apb(1'b0, cmf_pkg::APB_RXDATA, 32'h0);
            check(rd, {23'h0, i == q.size() - 1, q[i]});
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge i_clk);
        bad_count++;
        print_verdict();
    end
    // ======
    initial begin
        logic [2:0] qt[3] = '{3'h1, 3'h3, 3'h7};
        logic [2:0] ln[3] = '{3'h6, 3'h1, 3'h5};
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (qt[k]) begin
            send({8'h81 | {1'b0, qt[k], 4'h0}, 8'h03, 8'h07, 8'h05});
            quiet();
        end
        check({seen[4], seen[5]}, 16'h1ecf);
        send({8'h81, 8'h04, 8'h07, 8'h00});
        quiet();
        for (int k = 0; k < 3; k++) begin
            smp <= 16'($random(seed));
            if (k != 1) cs = $random(seed) | 32'h1;
            if (k == 0) av = 8'($random(seed));
            f = {8'h80 | {5'h0, ln[k]}, 8'h03, cmf_pkg::REG_SAMPLE_COMMAND, 8'h00};
            if (k != 1) f = {f, cs[31:24], cs[23:16], cs[15:8], cs[7:0]};
            if (k == 0) f.push_back(av);
            send(f);
            d = {};
            repeat ($countones(cs)) d = {d, smp[15:8], smp[7:0]};
            expect_rsp(d);
        end
        send({8'h81, 8'h03, cmf_pkg::REG_CHANNEL_SELECT, 8'h03});
        expect_rsp({cs[31:24], cs[23:16], cs[15:8], cs[7:0]});
        send({8'h81, 8'h03, cmf_pkg::REG_SAMPLE_AVERAGING, 8'h00});
        expect_rsp({av});
        apb(1'b0, 8'h14, 32'h0);
        check(err, 1'b1);
        print_verdict();
    end
endmodule
